//--- rtl/ticf_pkg.sv
// Package of constants and types for the input capture timer with filter
package ticf_pkg;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] ADDR_MODE    = 8'h00; // timer_mode_control
  localparam logic [7:0] ADDR_RUN     = 8'h04; // timer_run_status
  localparam logic [7:0] ADDR_SHARED  = 8'h08; // shared_output_filter_control
  localparam logic [7:0] ADDR_CAPTURE = 8'h0C; // capture_value
  localparam logic [7:0] ADDR_COUNT   = 8'h10; // live counter, read only
  localparam logic [7:0] ADDR_IRQ_ST  = 8'h14; // sticky event status, W1C
  localparam logic [7:0] ADDR_IRQ_MSK = 8'h18; // event mask
  localparam logic [7:0] ADDR_STANDBY = 8'h1C; // stop/watch hold request

  // ****************************************
  // Field positions
  // ****************************************
  // timer_mode_control
  localparam int MODE_LSB  = 0;  // mode select bits 3..0
  localparam int IFE_BIT   = 7;  // overflow_int_enable
  // timer_run_status
  localparam int RUN_BIT   = 7;  // run_control
  localparam int HOLD_BIT  = 6;  // suspend_request
  localparam int IE_BIT    = 5;  // capture_int_enable
  localparam int IR_BIT    = 4;  // edge_detect_flag
  localparam int BF_BIT    = 3;  // buffer_full_flag
  localparam int IF_BIT    = 2;  // overflow flag
  localparam int SO_BIT    = 1;  // output initial level
  localparam int OE_BIT    = 0;  // output enable
  // shared_output_filter_control
  localparam int TOUT_BIT  = 6;  // timer output level, read only
  localparam int FHI1_BIT  = 3;  // filter_sel_hi1
  localparam int FHI0_BIT  = 2;  // filter_sel_hi0
  localparam int FLO1_BIT  = 1;  // filter_sel_lo1
  localparam int FLO0_BIT  = 0;  // filter_sel_lo0
  // Status / mask bits
  localparam int EV_CAP    = 0;
  localparam int EV_OVF    = 1;

  // ****************************************
  // Mode codes, widths, reset values, timing
  // ****************************************
  localparam logic [3:0] MODE_CAP_CLR_RISE = 4'h8;
  localparam logic [3:0] MODE_CAP_CLR_FALL = 4'h9;
  localparam logic [3:0] MODE_CAP_CLR_BOTH = 4'hC;
  localparam logic [3:0] MODE_CAP_FR_RISE  = 4'hD;
  localparam logic [3:0] MODE_CAP_FR_FALL  = 4'hE;
  localparam logic [3:0] MODE_CAP_FR_BOTH  = 4'hF;
  localparam int          REG_W      = 8;
  localparam logic [7:0]  REG_RESET  = 8'h00;
  localparam logic [7:0]  COUNT_ZERO = 8'h00;
  localparam logic [7:0]  COUNT_MAX  = 8'hFF;
  localparam int          FILT_DEPTH = 4;   // pin delay with filter on
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;

  // Capture arming state
  typedef enum logic [2:0] {
    TICF_IDLE  = 3'b001,
    TICF_SKIP  = 3'b010,
    TICF_ARMED = 3'b100
  } ticf_arm_t;

endpackage

//--- rtl/ticf_top.sv
// Input capture timer with pulse noise filter and AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none

module ticf_top (
  // Clock and reset
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  // AXI4-Lite write address / data / response
  input  wire logic [7:0]                s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output var  logic                      s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output var  logic                      s_axi_wready,
  output var  logic [1:0]                s_axi_bresp,
  output var  logic                      s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  // AXI4-Lite read address / data
  input  wire logic [7:0]                s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output var  logic                      s_axi_arready,
  output var  logic [31:0]               s_axi_rdata,
  output var  logic [1:0]                s_axi_rresp,
  output var  logic                      s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  // External capture pin and timer output
  input  wire logic                      capture_input_pin,
  output var  logic                      timer_out,
  // Interrupt
  output var  logic                      irq
);
  import ticf_pkg::*;

  // ****************************************
  // Registers
  // ****************************************
  logic [REG_W-1:0] mode_ctl;
  logic [REG_W-1:0] run_ctl;      // RUN, HOLD, IE, SO, OE bits
  logic [3:0]       filt_sel;
  logic [REG_W-1:0] capture_data;
  logic [REG_W-1:0] count;
  logic             edge_detect_flag;
  logic             ovf_flag;
  logic             buffer_full_flag;
  logic             tout;
  logic [1:0]       irq_status;
  logic [1:0]       irq_mask;
  logic             standby_hold;
  logic             run_q;
  ticf_arm_t        arm_state;

  // ****************************************
  // AXI4-Lite slave handshakes
  // ****************************************
  logic       aw_held;
  logic       w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;

  // Address and data may arrive in either order; hold each until both
  wire aw_take  = s_axi_awvalid & s_axi_awready;
  wire w_take   = s_axi_wvalid & s_axi_wready;
  wire wr_fire  = aw_held & w_held & ~s_axi_bvalid;
  wire ar_take  = s_axi_arvalid & s_axi_arready;
  wire wr_lane0 = wr_fire & w_strb[0];
  // Response code comes from the held address, known before bvalid rises
  wire wr_map   = (aw_addr == ADDR_MODE)   | (aw_addr == ADDR_RUN)
                | (aw_addr == ADDR_SHARED) | (aw_addr == ADDR_CAPTURE)
                | (aw_addr == ADDR_COUNT)  | (aw_addr == ADDR_IRQ_ST)
                | (aw_addr == ADDR_IRQ_MSK)| (aw_addr == ADDR_STANDBY);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      // Ready drops on the take edge so a held valid is never taken twice
      s_axi_awready <= ~aw_held & ~aw_take;
      s_axi_wready  <= ~w_held & ~w_take;
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
      end
    end
  end

  // Write decode; only byte lane 0 carries register data
  wire wr_mode  = wr_lane0 & (aw_addr == ADDR_MODE);
  wire wr_run   = wr_lane0 & (aw_addr == ADDR_RUN);
  wire wr_shr   = wr_lane0 & (aw_addr == ADDR_SHARED);
  wire wr_cap   = wr_lane0 & (aw_addr == ADDR_CAPTURE);
  wire wr_ist   = wr_lane0 & (aw_addr == ADDR_IRQ_ST);
  wire wr_msk   = wr_lane0 & (aw_addr == ADDR_IRQ_MSK);
  wire wr_stby  = wr_lane0 & (aw_addr == ADDR_STANDBY);
  wire [7:0] wb = w_data[7:0];

  // Read mux; flags sit at their fixed bit places
  // The address is decoded live; it stands until taken, so the take sees it
  wire [7:0] run_rd = {run_ctl[RUN_BIT], run_ctl[HOLD_BIT], run_ctl[IE_BIT],
                       edge_detect_flag, buffer_full_flag, ovf_flag,
                       run_ctl[SO_BIT], run_ctl[OE_BIT]};
  wire [7:0] shr_rd = {1'b0, tout, 2'b00, filt_sel};
  logic [7:0] rd_byte;
  logic       rd_ok;
  always_comb begin
    rd_ok   = 1'b1;
    case (s_axi_araddr)
      ADDR_MODE:    rd_byte = mode_ctl;
      ADDR_RUN:     rd_byte = run_rd;
      ADDR_SHARED:  rd_byte = shr_rd;
      ADDR_CAPTURE: rd_byte = capture_data;
      ADDR_COUNT:   rd_byte = count;
      ADDR_IRQ_ST:  rd_byte = {6'd0, irq_status};
      ADDR_IRQ_MSK: rd_byte = {6'd0, irq_mask};
      ADDR_STANDBY: rd_byte = {7'd0, standby_hold};
      default: begin
        rd_byte = COUNT_ZERO;
        rd_ok   = 1'b0;
      end
    endcase
  end

  // Read channel: one outstanding read, answer the cycle after take
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~ar_take;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h00_0000, rd_byte};
        s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // Input noise filter
  // ****************************************
  // Three stored samples plus the live pin form a four-sample window;
  // a level whose pulses are filtered is accepted only once all four agree,
  // so its pulses of up to three clocks vanish; every kept edge arrives four clocks late
  logic [FILT_DEPTH-2:0] pin_hist;
  logic                  filt_q;
  wire [FILT_DEPTH-1:0] pin_win = {pin_hist, capture_input_pin};
  wire hist_hi = &pin_win;
  wire hist_lo = ~|pin_win;
  wire kill_hi = filt_sel[FHI1_BIT] | filt_sel[FHI0_BIT];
  wire kill_lo = filt_sel[FLO1_BIT] | filt_sel[FLO0_BIT];
  wire filt_on = kill_hi | kill_lo;
  // Rise needs a stable high only when high pulses are removed
  // Unfiltered direction still passes the stored samples, same delay
  wire next_filt = filt_q ? (kill_lo ? ~hist_lo : pin_hist[FILT_DEPTH-2])
                          : (kill_hi ?  hist_hi : pin_hist[FILT_DEPTH-2]);
  wire cap_in    = filt_on ? filt_q : capture_input_pin;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_hist <= '0;
      filt_q   <= 1'b0;
    end else begin
      pin_hist <= {pin_hist[FILT_DEPTH-3:0], capture_input_pin};
      filt_q   <= next_filt;
    end
  end

  // ****************************************
  // Edge detection and arming
  // ****************************************
  logic cap_prev;
  wire [3:0] mode = mode_ctl[MODE_LSB+3:MODE_LSB];
  wire running    = run_ctl[RUN_BIT];
  wire rise       = cap_in & ~cap_prev;
  wire fall       = ~cap_in & cap_prev;
  wire is_both    = (mode == MODE_CAP_CLR_BOTH) | (mode == MODE_CAP_FR_BOTH);
  wire is_rise    = (mode == MODE_CAP_CLR_RISE) | (mode == MODE_CAP_FR_RISE);
  wire is_fall    = (mode == MODE_CAP_CLR_FALL) | (mode == MODE_CAP_FR_FALL);
  wire is_clr     = (mode == MODE_CAP_CLR_RISE) | (mode == MODE_CAP_CLR_FALL)
                  | (mode == MODE_CAP_CLR_BOTH);
  wire is_cap     = is_both | is_rise | is_fall;
  wire start      = running & ~run_q;
  // Both-edge start with input high skips until the next rise
  wire skip_fall  = (arm_state == TICF_SKIP);
  wire sel_edge   = (is_rise & rise) | (is_fall & fall)
                  | (is_both & (rise | (fall & ~skip_fall)));
  wire cap_evt    = running & is_cap & (arm_state != TICF_IDLE) & sel_edge;
  wire hold_cnt   = run_ctl[HOLD_BIT] | standby_hold;
  // A stale FF left from an earlier run must not count as an overflow
  wire overflow   = running & ~hold_cnt & ~start & (count == COUNT_MAX);

  ticf_arm_t next_arm;
  always_comb begin
    case (arm_state)
      TICF_IDLE:  next_arm = start ? ((is_both & cap_in) ? TICF_SKIP
                                                         : TICF_ARMED)
                                   : TICF_IDLE;
      TICF_SKIP:  next_arm = !running ? TICF_IDLE
                           : (rise ? TICF_ARMED : TICF_SKIP);
      TICF_ARMED: next_arm = running ? TICF_ARMED : TICF_IDLE;
      default:    next_arm = TICF_IDLE;
    endcase
  end

  // ****************************************
  // Counter, capture, flags, output
  // ****************************************
  // Counter runs only while started and not held
  // A start always reloads zero, so a fresh run never inherits a count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count     <= COUNT_ZERO;
      cap_prev  <= 1'b0;
      run_q     <= 1'b0;
      arm_state <= TICF_IDLE;
    end else begin
      cap_prev  <= cap_in;
      run_q     <= running;
      arm_state <= next_arm;
      if (start)
        count <= COUNT_ZERO;
      else if (cap_evt && is_clr)
        count <= COUNT_ZERO;
      else if (running && !hold_cnt)
        count <= count + 8'h01;
    end
  end

  // Capture register; buffer-full is left alone by captures
  // A capture beats a software write landing in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn)
      capture_data <= REG_RESET;
    else if (cap_evt)
      capture_data <= count;
    else if (wr_cap)
      capture_data <= wb;
  end

  // Control and flag registers; hardware set beats software clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_ctl         <= REG_RESET;
      run_ctl          <= REG_RESET;
      filt_sel         <= 4'h0;
      edge_detect_flag <= 1'b0;
      ovf_flag         <= 1'b0;
      buffer_full_flag <= 1'b0;
      irq_mask         <= 2'b00;
      standby_hold     <= 1'b0;
    end else begin
      if (wr_mode) mode_ctl <= wb;
      if (wr_run)  run_ctl  <= wb;
      if (wr_shr)  filt_sel <= wb[3:0];
      if (wr_msk)  irq_mask <= wb[1:0];
      if (wr_stby) standby_hold <= wb[0];
      // Writing zero clears a flag; writing one leaves it
      edge_detect_flag <= cap_evt
                        | (edge_detect_flag & ~(wr_run & ~wb[IR_BIT]));
      ovf_flag         <= overflow
                        | (ovf_flag & ~(wr_run & ~wb[IF_BIT]));
      buffer_full_flag <= buffer_full_flag
                        & ~(wr_run & ~wb[BF_BIT]);
    end
  end

  // Timer output: load initial level on start, toggle on overflow
  // The level is kept while stopped, as overflow needs a running count
  always_ff @(posedge aclk) begin
    if (!aresetn)
      tout <= 1'b0;
    else if (start)
      tout <= run_ctl[SO_BIT];
    else if (overflow)
      tout <= ~tout;
  end

  // ****************************************
  // Interrupt status and output
  // ****************************************
  // Events reach status only when their enable bit is set
  wire [1:0] ev_now;
  assign ev_now[EV_CAP] = cap_evt & run_ctl[IE_BIT];
  assign ev_now[EV_OVF] = overflow & mode_ctl[IFE_BIT];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= 2'b00;
      irq       <= 1'b0;
      timer_out <= 1'b0;
    end else begin
      irq_status <= ev_now | (irq_status & ~({2{wr_ist}} & wb[1:0]));
      irq       <= |(irq_status & irq_mask);
      timer_out <= tout & run_ctl[OE_BIT];
    end
  end

endmodule

`default_nettype wire

//--- tb/ticf_pin_model.sv
// Behavioural driver of the external capture pin
`timescale 1ns/1ps
`default_nettype none
module ticf_pin_model (
  // Clock
  input  wire logic aclk,
  // Pulse line into the capture pin
  output var  logic pin
);
  // Idle low; the pin is always driven, it never floats
  initial pin = 1'b0;

  // Move to a new level just after the next edge
  task automatic level(input logic lvl);
    @(posedge aclk);
    pin <= lvl;
  endtask

  // Pulse of n clocks, then back to the opposite level
  task automatic pulse(input logic lvl, input int n);
    level(lvl);
    repeat (n) @(posedge aclk);
    pin <= ~lvl;
  endtask
endmodule
`default_nettype wire

//--- tb/ticf_top_properties.sv
// Port checks for the input capture timer
`timescale 1ns/1ps
`default_nettype none
module ticf_top_props
  import ticf_pkg::*;
(
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Timer output and interrupt
  input wire logic        timer_out,
  input wire logic        irq
);
  // All checks share one clock; reset masks all of them but p_quiet
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Outputs must be quiet right after a reset edge
  property p_quiet;
    disable iff (1'b0)
      !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !irq && !timer_out;
  endproperty
  a_quiet: assert property (p_quiet) else $error("outputs active after reset");

  // Answers stand, unchanged, until taken
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");

  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");

  // Read answer the cycle after the address is taken
  property p_r_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_answer: assert property (p_r_answer) else $error("read answer late");

  // Write answer within two cycles of a joint take
  property p_b_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_b_answer: assert property (p_b_answer) else $error("write answer late");

  // One transfer at a time per direction
  property p_w_busy;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_w_busy: assert property (p_w_busy) else $error("write taken while busy");

  property p_r_busy;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_r_busy: assert property (p_r_busy) else $error("read taken while busy");

  // Registers are one byte wide, legal codes only
  property p_r_word;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000
      && (s_axi_rresp == RESP_OKAY || s_axi_rresp == RESP_SLVERR);
  endproperty
  a_r_word: assert property (p_r_word) else $error("bad read word");
endmodule

bind ticf_top ticf_top_props u_props (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .timer_out, .irq);
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for the input capture timer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ticf_pkg::*;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        capture_input_pin, timer_out, irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  int          fails, cmp_count;

  ticf_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .capture_input_pin, .timer_out, .irq);
  ticf_pin_model pin_m (.aclk, .pin(capture_input_pin));

  // 100 MHz clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Verdict; every hang and the main sequence end here
  task automatic stop_test;
    if (fails == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chkb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask

  task automatic lost;
    fails++;
    stop_test;
  endtask

  // Bus write: address and data offered together, bounded wait
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 60);
    s_axi_bready <= 1'b0;
    rsp = s_axi_bresp;
    if (n >= 60) lost;
  endtask

  // Bus read into rd and rsp
  task automatic rdr(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 60);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    if (n >= 60) lost;
  endtask

  // Stop first, then clear flags and enables, before any mode change
  task automatic halt;
    wr(ADDR_RUN, 32'h0000_0000);
    wr(ADDR_MODE, 32'h0000_0000);
    wr(ADDR_IRQ_ST, 32'h0000_0003);
  endtask

  task automatic t_regs;
    rdr(ADDR_RUN);
    chk(rd, {24'h00_0000, REG_RESET});
    rdr(8'h20);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    wr(8'h20, 32'h0000_00FF);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    wr(ADDR_CAPTURE, 32'h0000_005A);
    chk({30'h0, rsp}, {30'h0, RESP_OKAY});
    rdr(ADDR_CAPTURE);
    chk(rd, 32'h0000_005A);
  endtask

  // Every capture mode: a 30-clock high pulse; short gap means fall last
  task automatic t_modes;
    logic [3:0] mt [6];
    logic [7:0] cap;
    logic [7:0] d;
    logic       clr;
    logic       rise_md;
    mt = '{MODE_CAP_CLR_RISE, MODE_CAP_CLR_FALL, MODE_CAP_CLR_BOTH,
           MODE_CAP_FR_RISE, MODE_CAP_FR_FALL, MODE_CAP_FR_BOTH};
    foreach (mt[i]) begin
      halt;
      wr(ADDR_MODE, {28'h0, mt[i]});
      wr(ADDR_RUN, 32'h0000_00A0);
      repeat (30) @(posedge aclk);
      pin_m.pulse(1'b1, 30);
      rdr(ADDR_RUN);
      chkb(rd[IR_BIT], 1'b1);
      chkb(rd[BF_BIT], 1'b0);
      rdr(ADDR_CAPTURE);
      cap = rd[7:0];
      rdr(ADDR_COUNT);
      clr = mt[i] inside {MODE_CAP_CLR_RISE, MODE_CAP_CLR_FALL,
                          MODE_CAP_CLR_BOTH};
      rise_md = mt[i] inside {MODE_CAP_CLR_RISE, MODE_CAP_FR_RISE};
      d = clr ? rd[7:0] : rd[7:0] - cap;
      chkb(d < 8'd25, !rise_md);
    end
  endtask

  // Both-edge start with the pin high: first fall is ignored
  task automatic t_skip;
    logic [3:0] bm [2];
    bm = '{MODE_CAP_CLR_BOTH, MODE_CAP_FR_BOTH};
    foreach (bm[i]) begin
      halt;
      pin_m.level(1'b1);
      wr(ADDR_MODE, {28'h0, bm[i]});
      wr(ADDR_RUN, 32'h0000_00A0);
      repeat (20) @(posedge aclk);
      pin_m.level(1'b0);
      repeat (20) @(posedge aclk);
      rdr(ADDR_RUN);
      chkb(rd[IR_BIT], 1'b0);
      rdr(ADDR_COUNT);
      chkb(rd[7:0] > 8'd30, 1'b1);
      pin_m.pulse(1'b1, 6);
      repeat (4) @(posedge aclk);
      rdr(ADDR_RUN);
      chkb(rd[IR_BIT], 1'b1);
    end
  endtask

  // High-pulse filter: three clocks removed, four pass
  task automatic t_filter;
    logic [7:0] cnt;
    halt;
    wr(ADDR_SHARED, 32'h0000_000C);
    wr(ADDR_MODE, {28'h0, MODE_CAP_FR_RISE});
    wr(ADDR_RUN, 32'h0000_00A0);
    pin_m.pulse(1'b1, 3);
    repeat (10) @(posedge aclk);
    rdr(ADDR_RUN);
    chkb(rd[IR_BIT], 1'b0);
    pin_m.pulse(1'b1, 4);
    repeat (10) @(posedge aclk);
    // Unfiltered, the rise is captured 15 counts before this read
    rdr(ADDR_COUNT);
    cnt = rd[7:0];
    rdr(ADDR_CAPTURE);
    chk(rd, {24'h0, cnt - 8'(15 - FILT_DEPTH)});
    rdr(ADDR_RUN);
    chkb(rd[IR_BIT], 1'b1);
    wr(ADDR_SHARED, 32'h0000_0000);
  endtask

  // Overflow flag, output toggle from its initial level, interrupt path
  task automatic t_ovf;
    halt;
    wr(ADDR_IRQ_MSK, 32'h0000_0003);
    wr(ADDR_MODE, {24'h0, 4'h8, MODE_CAP_FR_RISE});
    wr(ADDR_RUN, 32'h0000_0083);
    repeat (3) @(posedge aclk);
    chkb(timer_out, 1'b1);
    chkb(irq, 1'b0);
    repeat (270) @(posedge aclk);
    chkb(timer_out, 1'b0);
    chkb(irq, 1'b1);
    rdr(ADDR_RUN);
    chkb(rd[IF_BIT], 1'b1);
    wr(ADDR_IRQ_MSK, 32'h0000_0000);
    repeat (2) @(posedge aclk);
    chkb(irq, 1'b0);
    wr(ADDR_IRQ_MSK, 32'h0000_0003);
    wr(ADDR_IRQ_ST, 32'h0000_0002);
    repeat (2) @(posedge aclk);
    chkb(irq, 1'b0);
  endtask

  // Suspend and standby hold the count; restart after standby
  task automatic t_hold;
    logic [7:0] a;
    wr(ADDR_RUN, 32'h0000_00C3);
    rdr(ADDR_COUNT);
    a = rd[7:0];
    repeat (20) @(posedge aclk);
    rdr(ADDR_COUNT);
    chk(rd, {24'h0, a});
    wr(ADDR_RUN, 32'h0000_0083);
    wr(ADDR_STANDBY, 32'h0000_0001);
    rdr(ADDR_COUNT);
    a = rd[7:0];
    repeat (20) @(posedge aclk);
    rdr(ADDR_COUNT);
    chk(rd, {24'h0, a});
    wr(ADDR_STANDBY, 32'h0000_0000);
    rdr(ADDR_COUNT);
    chkb(rd[7:0] - a < 8'd12 && rd[7:0] != a, 1'b1);
    wr(ADDR_RUN, 32'h0000_0000);
    wr(ADDR_RUN, 32'h0000_0083);
    rdr(ADDR_COUNT);
    chkb(rd[7:0] < 8'd8, 1'b1);
  endtask

  // Main sequence
  initial begin
    aresetn       = 1'b0;
    s_axi_awaddr  = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata   = 32'h0000_0000;
    s_axi_wstrb   = 4'hF;
    s_axi_wvalid  = 1'b0;
    s_axi_bready  = 1'b0;
    s_axi_araddr  = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready  = 1'b0;
    fails         = 0;
    cmp_count     = 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_modes;
    t_skip;
    t_filter;
    t_ovf;
    t_hold;
    stop_test;
  end
endmodule
`default_nettype wire
